// File: pdni_core.sv
// Functional notes
// - Completed is asserted when the absolute position error is below done_width.
// - done_width ranges 0..1073741824, default 7, acts at once and only shapes status.
// - position_done_out is high (closed) when complete and low (open) otherwise.
// - done_timing_select is latched at reset; 0 needs only the error test.
// - Setting 1 also needs the filtered position reference to be zero.
// - Setting 2 also needs the raw position reference input to be zero.
// - Near is asserted while the absolute position error is below close_width.
// - close_width ranges 1..1073741824, default 1073741824, and acts at once.
// - position_near_out is high (closed) when near completion, low otherwise.
// - The near output drives only when a terminal is allocated to it.
// - While inhibited, reference pulses are not counted; counting resumes on release.
// - In allocation mode 0 with method B, mode_select_input closed inhibits counting.
// - With method B, mode_select_input drives nothing but the inhibit.
// - In allocation mode 1, pulse_block_input inhibits only for methods 1 or 5.
// - The inhibit acts only in position control and is ignored otherwise.
`timescale 1ns/1ps
`default_nettype none
module pdni_core
  import pdni_pkg::*;
#(
  parameter int ERR_W = pdni_pkg::PDNI_ERR_W
) (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_b,
  // Host pins, asynchronous, high = contact closed
  input  wire logic                         ref_pulse,
  input  wire logic                         ref_dir,
  input  wire logic                         mode_select_input,
  input  wire logic                         pulse_block_input,
  // Motor feedback and filter, same clock
  input  wire logic                         fb_step,
  input  wire logic                         fb_dir,
  input  wire logic                         filt_ref_zero,
  input  wire logic                         pos_ctrl_active,
  // Configuration
  input  wire logic [pdni_pkg::PDNI_WIDTH_W-1:0] done_width,
  input  wire logic [pdni_pkg::PDNI_WIDTH_W-1:0] close_width,
  input  wire logic [1:0]                   done_timing_select,
  input  wire logic [3:0]                   control_method_select,
  input  wire logic                         input_alloc_mode,
  input  wire logic [3:0]                   done_out_terminal_sel,
  input  wire logic [3:0]                   close_out_terminal_sel,
  input  wire logic [3:0]                   block_in_terminal_sel,
  // Status
  output var  logic                         position_done_out,
  output var  logic                         position_near_out,
  output var  logic                         position_near_oe,
  output var  logic                         pulse_inhibited,
  output var  logic                         mode_select_aux,
  output var  logic signed [ERR_W-1:0]      pos_err
);
  import pdni_pkg::*;

  // Synchronised pin levels
  logic [3:0] pins_s;
  logic       pulse_s;
  logic       dir_s;
  logic       msel_s;
  logic       blk_s;

  pdni_sync #(.N(4)) u_sync (
    .mclk (mclk),
    .rst_b(rst_b),
    .d    ({ref_pulse, ref_dir, mode_select_input, pulse_block_input}),
    .q    (pins_s)
  );
  assign {pulse_s, dir_s, msel_s, blk_s} = pins_s;

  // Timing selector only changes after restart, caught on the release edge
  logic         timing_loaded_reg;
  pdni_timing_t timing_reg;
  logic         pulse_d_reg;
  logic         done_reg;
  logic         near_reg;
  logic         raw_zero_reg;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      timing_loaded_reg <= 1'h0;
      timing_reg        <= PDNI_TIM_ERR_ONLY;
    end else if (!timing_loaded_reg) begin
      timing_loaded_reg <= 1'h1;
      case (done_timing_select)
        2'h1:    timing_reg <= PDNI_TIM_FILTERED;
        2'h2:    timing_reg <= PDNI_TIM_RAW;
        default: timing_reg <= PDNI_TIM_ERR_ONLY;
      endcase
    end
  end

  // Inhibit source selection
  wire method_b     = (control_method_select == PDNI_CM_POS_INH);
  wire method_15    = (control_method_select == PDNI_CM_POS) ||
                      (control_method_select == PDNI_CM_SPD_POS);
  wire fact_inh     = (input_alloc_mode == PDNI_ALLOC_FACT) && method_b && msel_s;
  wire user_inh     = (input_alloc_mode == PDNI_ALLOC_USER) && method_15 &&
                      (block_in_terminal_sel != PDNI_TERM_NONE) && blk_s;
  wire inhibit      = pos_ctrl_active && (fact_inh || user_inh);
  // With method B the select pin feeds no other function
  wire msel_aux     = msel_s && !method_b;

  // Pulse edge accepted only while not inhibited
  wire pulse_edge   = pulse_s && !pulse_d_reg;
  wire pulse_accept = pulse_edge && !inhibit;

  // Error update: reference up, feedback down
  logic signed [ERR_W-1:0] ref_step;
  logic signed [ERR_W-1:0] fb_delta;
  logic signed [ERR_W-1:0] pos_err_next;
  assign ref_step     = pulse_accept ? (dir_s ? -ERR_W'(1) : ERR_W'(1)) : '0;
  assign fb_delta     = fb_step ? (fb_dir ? -ERR_W'(1) : ERR_W'(1)) : '0;
  assign pos_err_next = pos_err + ref_step - fb_delta;

  // Magnitude compare on the current error
  logic [ERR_W-1:0] err_abs;
  assign err_abs = pos_err[ERR_W-1] ? ERR_W'(-pos_err) : ERR_W'(pos_err);
  wire below_done  = err_abs < ERR_W'(done_width);
  wire below_close = err_abs < ERR_W'(close_width);

  // Raw reference counted as zero when no pulse arrived in the last cycle
  wire done_cond =
    (timing_reg == PDNI_TIM_FILTERED) ? (below_done && filt_ref_zero) :
    (timing_reg == PDNI_TIM_RAW)      ? (below_done && raw_zero_reg)  :
                                        below_done;
  wire near_alloc = (close_out_terminal_sel != PDNI_TERM_NONE);

  // Widths are read live, so a new width acts on the next compare
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pos_err           <= '0;
      pulse_d_reg       <= 1'h0;
      raw_zero_reg      <= 1'h1;
      done_reg          <= 1'h0;
      near_reg          <= 1'h0;
    end else begin
      pos_err           <= pos_err_next;
      pulse_d_reg       <= pulse_s;
      raw_zero_reg      <= !pulse_edge;
      // Held low until the timing choice is caught, so a restart shows no false done
      done_reg          <= done_cond && timing_loaded_reg;
      near_reg          <= below_close && near_alloc;
    end
  end

  // Output flops; high means contact closed
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      position_done_out <= 1'h0;
      position_near_out <= 1'h0;
      position_near_oe  <= 1'h0;
      pulse_inhibited   <= 1'h0;
      mode_select_aux   <= 1'h0;
    end else begin
      position_done_out <= done_reg;
      position_near_out <= near_reg;
      position_near_oe  <= near_alloc;
      pulse_inhibited   <= inhibit;
      mode_select_aux   <= msel_aux;
    end
  end

  // done_out_terminal_sel only routes the pin outside this block
  logic unused_sel;
  assign unused_sel = ^done_out_terminal_sel;

  // Assertions
  AST_DONE_FOLLOWS: assert property (@(posedge mclk) disable iff (!rst_b)
    (timing_loaded_reg && timing_reg == PDNI_TIM_ERR_ONLY && below_done)
    |=> ##1 position_done_out)
    else $error("done not set after small error");
  AST_DONE_CLEARS: assert property (@(posedge mclk) disable iff (!rst_b)
    !below_done |=> ##1 !position_done_out)
    else $error("done set with large error");
  AST_FILT_GATE: assert property (@(posedge mclk) disable iff (!rst_b)
    (timing_reg == PDNI_TIM_FILTERED && !filt_ref_zero) |=> ##1 !position_done_out)
    else $error("done set with filtered reference moving");
  AST_RAW_GATE: assert property (@(posedge mclk) disable iff (!rst_b)
    (timing_reg == PDNI_TIM_RAW && pulse_edge) |=> ##2 !position_done_out)
    else $error("done set with raw reference moving");
  AST_NEAR: assert property (@(posedge mclk) disable iff (!rst_b)
    (below_close && near_alloc) |=> ##1 position_near_out)
    else $error("near not set");
  AST_NEAR_ALLOC: assert property (@(posedge mclk) disable iff (!rst_b)
    !near_alloc |=> ##1 !position_near_out)
    else $error("near driven while unallocated");
  AST_INHIBIT_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    (inhibit && !fb_step) |=> pos_err == $past(pos_err))
    else $error("pulse counted while inhibited");
  AST_INH_POS_ONLY: assert property (@(posedge mclk) disable iff (!rst_b)
    !pos_ctrl_active |=> !pulse_inhibited)
    else $error("inhibit outside position control");
  AST_METHOD_B: assert property (@(posedge mclk) disable iff (!rst_b)
    method_b |=> !mode_select_aux)
    else $error("select pin used beyond inhibit");
  AST_COUNT: assert property (@(posedge mclk) disable iff (!rst_b)
    (pulse_accept && !dir_s && !fb_step) |=> pos_err == $past(pos_err) + ERR_W'(1))
    else $error("accepted pulse not counted");
  AST_NEAR_CLEARS: assert property (@(posedge mclk) disable iff (!rst_b)
    !below_close |=> ##1 !position_near_out)
    else $error("near set with large error");
  AST_FACT_INH: assert property (@(posedge mclk) disable iff (!rst_b)
    (pos_ctrl_active && input_alloc_mode == PDNI_ALLOC_FACT && method_b && msel_s)
    |=> pulse_inhibited)
    else $error("select pin did not inhibit under method B");
  AST_USER_INH: assert property (@(posedge mclk) disable iff (!rst_b)
    (input_alloc_mode == PDNI_ALLOC_USER && !method_15) |=> !pulse_inhibited)
    else $error("pulse block honoured outside methods 1 and 5");
  AST_TIMING_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    timing_loaded_reg |=> $stable(timing_reg))
    else $error("timing choice changed without restart");
  AST_DONE_NO_LOAD: assert property (@(posedge mclk) disable iff (!rst_b)
    !timing_loaded_reg |=> ##1 !position_done_out)
    else $error("done set before timing choice caught");

  COV_DONE: cover property (@(posedge mclk) disable iff (!rst_b) $rose(position_done_out));
  COV_NEAR: cover property (@(posedge mclk) disable iff (!rst_b) $rose(position_near_out));
  COV_INH:  cover property (@(posedge mclk) disable iff (!rst_b) pulse_edge && inhibit);
  COV_RAW:  cover property (@(posedge mclk) disable iff (!rst_b)
    timing_reg == PDNI_TIM_RAW && pulse_edge);
endmodule // pdni_core
`default_nettype wire

// File: pdni_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller model: reference pulse source and status reader
module pdni_host (
  // Clock
  input  wire logic       mclk,
  // Command from bench
  input  wire logic       start,
  input  wire logic [7:0] n_pulses,
  input  wire logic       dir,
  // Status from device
  input  wire logic       done_in,
  input  wire logic       near_in,
  // Pins and status for bench
  output var  logic       ref_pulse,
  output var  logic       ref_dir,
  output var  logic       busy,
  output var  logic       prep_next,
  output var  logic       pos_final
);
  logic [9:0] phase_reg = 10'h000;

  // Two cycles high, two low per pulse, so the pin synchroniser never misses one
  always_ff @(posedge mclk) begin
    if (start && phase_reg == 10'h000) begin
      phase_reg <= {n_pulses, 2'h0};
    end else if (phase_reg != 10'h000) begin
      phase_reg <= phase_reg - 10'h001;
    end
  end

  // Pins and sequence status
  assign ref_pulse = phase_reg[1];
  assign ref_dir   = dir;                 // Held by the bench across a burst
  assign busy      = phase_reg != 10'h000;
  assign prep_next = near_in & ~done_in;
  assign pos_final = done_in;
endmodule // pdni_host
`default_nettype wire

// File: pdni_pkg.sv
package pdni_pkg;
  // Position error and width datapath
  localparam int          PDNI_ERR_W        = 32;
  localparam int          PDNI_WIDTH_W      = 31;
  localparam logic [30:0] PDNI_WIDTH_MAX    = 31'h40000000;
  localparam logic [30:0] PDNI_DONE_W_RST   = 31'h00000007;
  localparam logic [30:0] PDNI_CLOSE_W_RST  = 31'h40000000;
  localparam logic [30:0] PDNI_CLOSE_W_MIN  = 31'h00000001;

  // Completion timing selector values
  typedef enum logic [1:0] {
    PDNI_TIM_ERR_ONLY = 2'h0,
    PDNI_TIM_FILTERED = 2'h1,
    PDNI_TIM_RAW      = 2'h2
  } pdni_timing_t;

  // Control method codes that involve the inhibit
  localparam logic [3:0]  PDNI_CM_POS       = 4'h1;
  localparam logic [3:0]  PDNI_CM_SPD_POS   = 4'h5;
  localparam logic [3:0]  PDNI_CM_POS_INH   = 4'hb;

  // Input allocation modes
  localparam logic        PDNI_ALLOC_FACT   = 1'h0;
  localparam logic        PDNI_ALLOC_USER   = 1'h1;

  // Terminal select value meaning "not allocated"
  localparam logic [3:0]  PDNI_TERM_NONE    = 4'h0;
endpackage

// File: pdni_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for asynchronous pins
module pdni_sync #(
  parameter int N = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_b,
  // Data
  input  wire logic [N-1:0] d,
  output var  logic [N-1:0] q
);
  logic [N-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // pdni_sync
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pdni_pkg::*;
  logic mclk = 0, rst_b = 0, start = 0, dir = 0, msel = 0, blk = 0;
  logic fb_step = 0, fb_dir = 0, fzero = 1, pact = 1, am = PDNI_ALLOC_FACT;
  logic [30:0] dw = PDNI_DONE_W_RST, cw = PDNI_CLOSE_W_RST;
  logic [1:0] tsel = 2'h0;
  logic [3:0] cm = PDNI_CM_POS, nsel = 4'h2, bsel = 4'h3;
  logic [7:0] npul = 8'h00;
  logic rp, rd, busy, done, near, noe, inh, aux, prep, fin;
  logic signed [31:0] err;
  int n_fail = 0, num_checks = 0;
  // Free-running 50 MHz clock
  always #10 mclk = ~mclk;
  pdni_host u_pdni_host (.mclk(mclk), .start(start), .n_pulses(npul), .dir(dir),
    .done_in(done), .near_in(near), .ref_pulse(rp), .ref_dir(rd), .busy(busy),
    .prep_next(prep), .pos_final(fin));
  pdni_core u_pdni_core (.mclk(mclk), .rst_b(rst_b), .ref_pulse(rp), .ref_dir(rd),
    .mode_select_input(msel), .pulse_block_input(blk), .fb_step(fb_step),
    .fb_dir(fb_dir), .filt_ref_zero(fzero), .pos_ctrl_active(pact), .done_width(dw),
    .close_width(cw), .done_timing_select(tsel), .control_method_select(cm),
    .input_alloc_mode(am), .done_out_terminal_sel(4'h1), .close_out_terminal_sel(nsel),
    .block_in_terminal_sel(bsel), .position_done_out(done), .position_near_out(near),
    .position_near_oe(noe), .pulse_inhibited(inh), .mode_select_aux(aux), .pos_err(err));
  // Shared compare, closing report and timing helpers
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic do_reset(input logic [1:0] t);
    rst_b = 1'b0;
    tsel = t;
    cyc(2);
    rst_b = 1'b1;
    cyc(6);
  endtask
  // Burst of n pulses; bounded wait on the host, then let the error settle
  task automatic pulses(input logic [7:0] n, input logic d);
    npul = n;
    dir = d;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    for (int i = 0; i < 200 && busy; i++) cyc(1);
    if (busy) begin
      n_fail++;
      stop_test();
    end
    cyc(8);
  endtask
  task automatic feedback(input int k, input logic d);
    fb_dir = d;
    repeat (k) begin
      fb_step = 1'b1;
      cyc(1);
      fb_step = 1'b0;
      cyc(1);
    end
    cyc(4);
  endtask
  // Scenarios
  task automatic t_reset;
    rst_b = 1'b0;
    cyc(2);
    check({err, done, near, noe, inh}, 36'h0);
    rst_b = 1'b1;
    cyc(5);
    check({done, near, noe}, 3'h7);
    nsel = 4'h0;
    cyc(4);
    check({near, noe}, 2'h0);
    nsel = 4'h2;
    cyc(4);
    $display("test reset done");
  endtask
  task automatic t_done;
    dw = 31'h3;
    cw = 31'h6;
    pulses(8'h05, 1'b0);
    check(err, 32'h5);
    check({done, near}, 2'h1);
    check({prep, fin}, 2'h2);
    pulses(8'h01, 1'b0);
    check(near, 1'b0);
    feedback(3, 1'b0);
    check({err, done}, {32'h3, 1'b0});
    feedback(1, 1'b0);
    check(done, 1'b1);
    check({prep, fin}, 2'h1);
    pulses(8'h04, 1'b1);
    check({err, done}, {-32'sd2, 1'b1});
    cw = 31'h2;
    cyc(4);
    check(near, 1'b0);
    feedback(2, 1'b1);
    $display("test done_near done");
  endtask
  task automatic t_inh_b;
    cm = PDNI_CM_POS;
    msel = 1'b1;
    cyc(5);
    check({inh, aux}, 2'h1);
    cm = PDNI_CM_POS_INH;
    cyc(5);
    check({inh, aux}, 2'h2);
    pulses(8'h03, 1'b0);
    check(err, 32'h0);
    msel = 1'b0;
    cyc(5);
    pulses(8'h03, 1'b0);
    check(err, 32'h3);
    $display("test inhibit_b done");
  endtask
  task automatic t_inh_user;
    am = PDNI_ALLOC_USER;
    blk = 1'b1;
    cm = PDNI_CM_SPD_POS;
    cyc(5);
    check(inh, 1'b1);
    bsel = 4'h0;
    cyc(5);
    check(inh, 1'b0);
    bsel = 4'h3;
    cm = 4'h3;
    cyc(5);
    check(inh, 1'b0);
    cm = PDNI_CM_POS;
    pulses(8'h02, 1'b0);
    check({err, inh}, {32'h3, 1'b1});
    pact = 1'b0;
    cyc(5);
    pulses(8'h02, 1'b0);
    check({err, inh}, {32'h5, 1'b0});
    $display("test inhibit_user done");
  endtask
  task automatic t_timing;
    logic gap;
    fzero = 1'b0;
    do_reset(2'h1);
    check(done, 1'b0);
    fzero = 1'b1;
    cyc(5);
    check(done, 1'b1);
    fzero = 1'b0;
    do_reset(2'h2);
    check(done, 1'b1);
    // Raw gating: done must drop at least once during the burst even with a small error
    gap = 1'b0;
    npul = 8'h02;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    for (int i = 0; i < 40 && busy; i++) begin
      if (!done) gap = 1'b1;
      cyc(1);
    end
    check(gap, 1'b1);
    cyc(8);
    check({err, done}, {32'h2, 1'b1});
    $display("test timing done");
  endtask
  initial begin
    t_reset();
    t_done();
    t_inh_b();
    t_inh_user();
    t_timing();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
